// ==== logic/mcmode_pkg.sv ====
package mcmode_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_MAIN = 8'h00;
	localparam logic [7:0] OFF_PHASE = 8'h04;
	localparam logic [7:0] OFF_MODE = 8'h08;
	localparam logic [7:0] OFF_WEIGHT = 8'h0c;
	localparam logic [7:0] OFF_PREV_ZC = 8'h10;
	localparam logic [7:0] OFF_CUR_ZC = 8'h14;
	localparam logic [7:0] OFF_NEXT_CMP = 8'h18;
	localparam logic [7:0] OFF_SYS = 8'h1c;
	localparam logic [7:0] OFF_DUTY = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;
	// Main control field positions
	localparam int unsigned BIT_OE = 7;
	localparam int unsigned BIT_CKE = 6;
	localparam int unsigned BIT_SENSOR = 5;
	localparam int unsigned BIT_DAC = 4;
	localparam int unsigned BIT_REG = 3;
	localparam int unsigned BIT_AUTO = 2;
	localparam int unsigned BIT_PZ = 1;
	localparam int unsigned BIT_CAP = 0;
	// System control field positions
	localparam int unsigned BIT_ZC_STOP = 0;
	localparam int unsigned BIT_HI_RATE = 1;
	// Status field positions
	localparam int unsigned BIT_FROZEN = 16;
	localparam int unsigned BIT_ZC_RUN = 17;
	// Values after reset
	localparam logic [7:0] RST_MAIN = 8'h00;
	localparam logic [5:0] RST_PHASE = 6'h00;
	localparam logic [2:0] RST_MODE = 3'h0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_SYS = 2'h0;
	localparam logic [11:0] RST_DUTY = 12'h000;
	// PWM counter width and multiplier scaling (divide by 256)
	localparam int unsigned PWM_W = 12;
	localparam int unsigned MULT_SHIFT = 8;
	// Reset-state option of the phase outputs
	typedef enum logic [1:0] {
		RSTATE_HIZ = 2'h0,
		RSTATE_LOW = 2'h1,
		RSTATE_HIGH = 2'h2
	} mcmode_rstate_t;
endpackage

// ==== logic/mcmode_mult_if.sv ====
`timescale 1ns/1ps
interface mcmode_mult_if;
	logic [7:0] weight;
	logic [7:0] operand;
	logic [7:0] result;
	modport ctrl (output weight, output operand, input result);
	modport mult (input weight, input operand, output result);
endinterface

// ==== logic/mcmode_mult.sv ====
`timescale 1ns/1ps
module mcmode_mult (
	// Operands and scaled product
	mcmode_mult_if.mult m
);
	logic [15:0] product;

	assign product = 16'(m.weight) * 16'(m.operand);
	// Keeping only the upper byte is the divide by 256
	assign m.result = product[15:mcmode_pkg::MULT_SHIFT];
endmodule // mcmode_mult

// ==== logic/mcmode_ctrl.sv ====
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - Output enable bit 7: clear holds phase outputs in reset state, set drives them.
// - Output enable clear forces reset state: high impedance, high or low by option.
// - Outputs off, sensorless, PWM-rate sampling: stop bit halts zero-crossing sampling.
// - Clock enable bit 6 clear stops internal clocks; events ignored, preloads frozen.
// - Register writes still work while the internal clocks are stopped.
// - Direct access without clocks gives static levels; with clocks PWM may apply.
// - Voltage mode, clocks stopped, outputs on: PWM-carrying outputs stay at 1.
// - Current mode, clocks stopped, outputs on, no direct access: PWM-carrying outputs go to 0.
// - Outputs at static 1 stay at 1 when clocks stop.
// - PWM counter is held at zero while clock enable is clear.
// - Setting clock enable copies update-event preload registers to active ones.
// - Sensor bit 5: 0 sensorless three PWM phases, 1 sensor, middle mode ignored.
// - Without direct access, preloaded phase and high mode bit apply at next commutation.
// - Direct access phase write drives outputs and raises a commutation event now.
// - Bit 3 selects voltage mode when 0 and current mode when 1.
// - Bit 2 selects switched or autoswitched; next compare always read and write.
// - Bit 1 enables parasitic zero-crossing protection and bypasses the event filter.
// - Bit 0 picks previous or current capture; compare is weight times capture / 256.
// - Autoswitched mode loads the weighted product into next compare at zero crossing.
module mcmode_ctrl (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Event inputs from the sampling logic
	input wire logic commutation_event,
	input wire logic zc_event,
	input wire logic [7:0] zc_value,
	// Reset-state option strap
	input wire logic [1:0] reset_state_opt,
	// Phase outputs to the power stage
	output logic [5:0] phase_outputs,
	output logic [5:0] phase_outputs_oe_n,
	// Mode and control outputs
	output logic periph_clk_en,
	output logic commutation_out,
	output logic update_pulse,
	output logic zc_sampling_run,
	output logic demag_sampling,
	output logic zc_filter_bypass,
	output logic three_phase_pwm,
	output logic current_mode,
	output logic auto_mode,
	output logic [2:0] output_mode_bits
);
	logic [7:0] motor_main_control;
	logic [5:0] phase_pre;
	logic [5:0] phase_act;
	logic [2:0] mode_pre;
	logic mode_hi_act;
	logic [7:0] multiplier_weight;
	logic [7:0] previous_zc_capture;
	logic [7:0] current_zc_capture;
	logic [7:0] next_compare_reg;
	logic [1:0] system_control_reg;
	logic [11:0] duty_pre;
	logic [11:0] duty_act;
	logic [11:0] pwm_cnt;
	logic cke_q;
	logic after_zc;
	logic [1:0] opt_meta;
	logic [1:0] opt_sync;
	logic [31:0] rd_mux;
	logic mapped;
	mcmode_mult_if mif ();

	wire oe = motor_main_control[mcmode_pkg::BIT_OE];
	wire cke = motor_main_control[mcmode_pkg::BIT_CKE];
	wire sensor_select = motor_main_control[mcmode_pkg::BIT_SENSOR];
	wire dac = motor_main_control[mcmode_pkg::BIT_DAC];
	wire capture_source_select = motor_main_control[mcmode_pkg::BIT_CAP];
	wire zc_stop = system_control_reg[mcmode_pkg::BIT_ZC_STOP];
	wire hi_rate = system_control_reg[mcmode_pkg::BIT_HI_RATE];

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// APB decode
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire wr = access & pwrite;
	wire wr_main = wr & hit(paddr, mcmode_pkg::OFF_MAIN);
	wire wr_phase = wr & hit(paddr, mcmode_pkg::OFF_PHASE);
	wire wr_mode = wr & hit(paddr, mcmode_pkg::OFF_MODE);
	wire wr_weight = wr & hit(paddr, mcmode_pkg::OFF_WEIGHT);
	wire wr_prev = wr & hit(paddr, mcmode_pkg::OFF_PREV_ZC);
	wire wr_cur = wr & hit(paddr, mcmode_pkg::OFF_CUR_ZC);
	wire wr_cmp = wr & hit(paddr, mcmode_pkg::OFF_NEXT_CMP);
	wire wr_sys = wr & hit(paddr, mcmode_pkg::OFF_SYS);
	wire wr_duty = wr & hit(paddr, mcmode_pkg::OFF_DUTY);

	// Hardware events only count while the internal clocks run; a direct access phase write commutes at any time
	wire zc_seen = cke & zc_event;
	wire comm_seen = cke & commutation_event & ~dac;
	wire direct_comm = dac & wr_phase;
	wire c_event = comm_seen | direct_comm;
	wire cke_rise = cke & ~cke_q;
	wire pwm_wrap = cke & (pwm_cnt == {mcmode_pkg::PWM_W{1'b1}});
	wire duty_load = cke_rise | pwm_wrap;
	wire pwm_raw = (pwm_cnt < duty_act);
	wire frozen = ~cke & oe & ~dac;
	wire auto_load = zc_seen & motor_main_control[mcmode_pkg::BIT_AUTO];

	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		if (hit(paddr, mcmode_pkg::OFF_MAIN)) begin
			rd_mux[7:0] = motor_main_control;
		end else if (hit(paddr, mcmode_pkg::OFF_PHASE)) begin
			rd_mux[5:0] = phase_pre;
		end else if (hit(paddr, mcmode_pkg::OFF_MODE)) begin
			rd_mux[2:0] = mode_pre;
		end else if (hit(paddr, mcmode_pkg::OFF_WEIGHT)) begin
			rd_mux[7:0] = multiplier_weight;
		end else if (hit(paddr, mcmode_pkg::OFF_PREV_ZC)) begin
			rd_mux[7:0] = previous_zc_capture;
		end else if (hit(paddr, mcmode_pkg::OFF_CUR_ZC)) begin
			rd_mux[7:0] = current_zc_capture;
		end else if (hit(paddr, mcmode_pkg::OFF_NEXT_CMP)) begin
			rd_mux[7:0] = next_compare_reg;
		end else if (hit(paddr, mcmode_pkg::OFF_SYS)) begin
			rd_mux[1:0] = system_control_reg;
		end else if (hit(paddr, mcmode_pkg::OFF_DUTY)) begin
			rd_mux[11:0] = duty_pre;
		end else if (hit(paddr, mcmode_pkg::OFF_STATUS)) begin
			rd_mux[11:0] = pwm_cnt;
			rd_mux[mcmode_pkg::BIT_FROZEN] = frozen;
			rd_mux[mcmode_pkg::BIT_ZC_RUN] = zc_sampling_run;
		end else begin
			mapped = 1'b0;
		end
	end

	assign pready = 1'b1;
	assign pslverr = access & ~mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup & ~pwrite) begin
			prdata <= rd_mux;
		end
	end

	// Option strap crosses in from a pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opt_meta <= 2'h0;
			opt_sync <= 2'h0;
		end else begin
			opt_meta <= reset_state_opt;
			opt_sync <= opt_meta;
		end
	end

	// Software registers; writes never depend on clock enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			motor_main_control <= mcmode_pkg::RST_MAIN;
			phase_pre <= mcmode_pkg::RST_PHASE;
			mode_pre <= mcmode_pkg::RST_MODE;
			multiplier_weight <= mcmode_pkg::RST_BYTE;
			system_control_reg <= mcmode_pkg::RST_SYS;
			duty_pre <= mcmode_pkg::RST_DUTY;
		end else begin
			if (wr_main) motor_main_control <= pwdata[7:0];
			if (wr_phase) phase_pre <= pwdata[5:0];
			if (wr_mode) mode_pre <= pwdata[2:0];
			if (wr_weight) multiplier_weight <= pwdata[7:0];
			if (wr_sys) system_control_reg <= pwdata[1:0];
			if (wr_duty) duty_pre <= pwdata[11:0];
		end
	end

	// Captures and next compare; a hardware event beats a same-cycle write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			previous_zc_capture <= mcmode_pkg::RST_BYTE;
			current_zc_capture <= mcmode_pkg::RST_BYTE;
			next_compare_reg <= mcmode_pkg::RST_BYTE;
		end else begin
			if (zc_seen) begin
				previous_zc_capture <= current_zc_capture;
				current_zc_capture <= zc_value;
			end else begin
				if (wr_prev) previous_zc_capture <= pwdata[7:0];
				if (wr_cur) current_zc_capture <= pwdata[7:0];
			end
			if (auto_load) begin
				next_compare_reg <= mif.result;
			end else if (wr_cmp) begin
				next_compare_reg <= pwdata[7:0];
			end
		end
	end

	// Operand as the capture registers will hold it after this event
	assign mif.weight = multiplier_weight;
	assign mif.operand = capture_source_select ? zc_value : current_zc_capture;

	mcmode_mult u_mult (
		.m(mif.mult)
	);

	// Active phase state and preload-only high mode bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_act <= mcmode_pkg::RST_PHASE;
			mode_hi_act <= 1'b0;
			after_zc <= 1'b0;
			commutation_out <= 1'b0;
		end else begin
			if (direct_comm) begin
				phase_act <= pwdata[5:0];
			end else if (comm_seen) begin
				phase_act <= phase_pre;
			end
			if (c_event) mode_hi_act <= mode_pre[2];
			if (c_event) begin
				after_zc <= 1'b0;
			end else if (zc_seen) begin
				after_zc <= 1'b1;
			end
			commutation_out <= c_event;
		end
	end

	// PWM generator with update-event preload of the duty
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_cnt <= 12'h000;
			duty_act <= mcmode_pkg::RST_DUTY;
			cke_q <= 1'b0;
			update_pulse <= 1'b0;
		end else begin
			pwm_cnt <= cke ? pwm_cnt + 12'h001 : 12'h000;
			if (duty_load) duty_act <= duty_pre;
			cke_q <= cke;
			update_pulse <= duty_load;
		end
	end

	// Low mode bit picks the channel group in direct access
	wire group_low = (dac | after_zc) ? mode_pre[0] : mode_hi_act;
	// Stopped clocks: static level in direct access, else the regulation mode decides
	wire pwm_eff = cke ? pwm_raw : (dac | ~current_mode);
	wire rst_high = (opt_sync == mcmode_pkg::RSTATE_HIGH);
	wire rst_hiz = (opt_sync == mcmode_pkg::RSTATE_HIZ);
	logic [5:0] pwm_mask;
	logic [5:0] next_out;

	// Even outputs are low channels, odd outputs high channels
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_phase
			assign pwm_mask[gi] = ((gi % 2) == 0) ? group_low : ~group_low;
			// A static 1 stays 1 even with clocks stopped
			assign next_out[gi] = oe ?
				(phase_act[gi] & (pwm_mask[gi] ? pwm_eff : 1'b1)) : rst_high;
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_outputs <= 6'h00;
			phase_outputs_oe_n <= 6'h3f;
		end else begin
			phase_outputs <= next_out;
			phase_outputs_oe_n <= {6{~oe & rst_hiz}};
		end
	end

	// Mode outputs
	assign periph_clk_en = cke;
	assign current_mode = motor_main_control[mcmode_pkg::BIT_REG];
	assign auto_mode = motor_main_control[mcmode_pkg::BIT_AUTO];
	assign zc_filter_bypass = motor_main_control[mcmode_pkg::BIT_PZ];
	assign three_phase_pwm = ~sensor_select;
	assign output_mode_bits = {mode_hi_act, mode_pre[1] & ~sensor_select, mode_pre[0]};
	assign zc_sampling_run = cke & ~(~oe & ~sensor_select & ~hi_rate & zc_stop);
	assign demag_sampling = cke & ~zc_sampling_run;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_direct_write;
		dac && wr_phase;
	endsequence
	sequence s_comm_then_drive;
		commutation_out ##1 (oe -> (phase_act == $past(pwdata[5:0], 2)));
	endsequence

	a_reset_state_hold: assert property (!oe |=> (phase_outputs_oe_n == {6{rst_hiz}}) || !$stable(opt_sync))
		else $error("phase outputs not in reset state");
	a_pwm_cnt_held: assert property (!cke ##1 !cke |-> pwm_cnt == 12'h000)
		else $error("pwm counter not held");
	a_preload_on_cke: assert property ($rose(cke) |=> duty_act == $past(duty_pre))
		else $error("preload not transferred");
	a_write_clk_off: assert property (!cke && wr_weight |=> multiplier_weight == $past(pwdata[7:0]))
		else $error("write lost while clocks off");
	a_direct_commut: assert property (s_direct_write |=> s_comm_then_drive)
		else $error("direct write without commutation");
	a_auto_compare: assert property (auto_load |=> next_compare_reg == $past(mif.result))
		else $error("next compare not loaded");
	a_std_commut: assert property (comm_seen |=> phase_act == $past(phase_pre))
		else $error("preload phase not applied");
	a_volt_freeze: assert property (frozen && !current_mode && $stable(phase_act) |=> phase_outputs == $past(phase_act))
		else $error("voltage freeze level wrong");
	a_curr_freeze: assert property (frozen && current_mode |=> phase_outputs == $past(phase_act & ~pwm_mask))
		else $error("current freeze level wrong");
	a_zc_stop_run: assert property (cke && !oe && !sensor_select && !hi_rate |-> zc_sampling_run != zc_stop)
		else $error("sampling stop not honoured");
	a_no_pwm_clk_off: assert property (!cke && oe && dac ##1 !cke |-> phase_outputs == $past(phase_act))
		else $error("direct access not static");
endmodule // mcmode_ctrl

// ==== test/mcmode_power_stage.sv ====
`timescale 1ns/1ps
// Gate drivers of the inverter; a released gate floats, so it shows the
// inverse of its last level and a stale value can never pass for a drive
module mcmode_power_stage (
	// Clock
	input wire logic pclk,
	// Gate drive from the controller
	input wire logic [5:0] gate_in,
	input wire logic [5:0] gate_oe_n,
	// Level seen at each gate
	output logic [5:0] gate_level
);
	logic [5:0] last_level;
	initial last_level = 6'h00;
	always @(posedge pclk) begin
		last_level <= gate_level;
	end
	assign gate_level = (gate_in & ~gate_oe_n) | (~last_level & gate_oe_n);
endmodule // mcmode_power_stage

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, zc_value, w, v1, v2, v3;
	logic [31:0] pwdata, prdata, rd, seed, v;
	logic commutation_event, zc_event, periph_clk_en, commutation_out, update_pulse;
	logic zc_sampling_run, demag_sampling, zc_filter_bypass, three_phase_pwm;
	logic current_mode, auto_mode;
	logic [1:0] reset_state_opt;
	logic [2:0] output_mode_bits;
	logic [5:0] phase_outputs, phase_outputs_oe_n, gate_level;
	int miscompares, n_checks, n_comm, n_upd, cycles, n;
	mcmode_ctrl i_mcmode_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .commutation_event, .zc_event, .zc_value,
		.reset_state_opt, .phase_outputs, .phase_outputs_oe_n, .periph_clk_en,
		.commutation_out, .update_pulse, .zc_sampling_run, .demag_sampling,
		.zc_filter_bypass, .three_phase_pwm, .current_mode, .auto_mode, .output_mode_bits);
	mcmode_power_stage i_mcmode_power_stage (.pclk(pclk), .gate_in(phase_outputs),
		.gate_oe_n(phase_outputs_oe_n), .gate_level(gate_level));
	always #2.5 pclk = ~pclk;
	// Pulses counted, so a check does not hinge on their exact cycle
	always @(posedge pclk) begin
		cycles++;
		if (commutation_out === 1'b1) n_comm++;
		if (update_pulse === 1'b1) n_upd++;
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end
	function logic [31:0] next_rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function logic [31:0] exp_cmp(input logic [7:0] a, input logic [7:0] b);
		return (32'(a) * 32'(b)) >> 8;
	endfunction
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
			miscompares++;
		end
	endtask
	task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= we;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(name, exp, rd);
	endtask
	task automatic settle(input int k);
		repeat (k) @(posedge pclk);
		#1;
	endtask
	task automatic zc(input logic [7:0] val);
		@(posedge pclk);
		zc_event <= 1'b1;
		zc_value <= val;
		@(posedge pclk);
		zc_event <= 1'b0;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		{pclk, presetn, psel, penable, pwrite, commutation_event, zc_event} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		zc_value = 8'h00;
		reset_state_opt = 2'h0;
		seed = 32'h03018bf9;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		settle(4);
		rdchk("main", 8'h00, 32'h0);
		chk("oe_n", 32'h3f, 32'(phase_outputs_oe_n));
		apb(1'b0, 8'h3c, 32'h0);
		chk("slverr", 32'h1, 32'(err));
		chk("unmapped", 32'h0, rd);
		for (int s = 1; s < 3; s++) begin
			reset_state_opt <= 2'(s);
			settle(5);
			chk("oe_n", 32'h0, 32'(phase_outputs_oe_n));
			chk("gate", (s == 2) ? 32'h3f : 32'h0, 32'(gate_level));
		end
		$display("test reset state done");
		for (int i = 0; i < 8; i++) begin
			// Outputs kept off so the frozen setup never arises
			v = (i == 0) ? 32'h0 : (i == 1) ? 32'h7f : next_rnd() & 32'h7f;
			apb(1'b1, 8'h00, v);
			settle(2);
			rdchk("main", 8'h00, v);
			chk("clk_en", 32'(v[6]), 32'(periph_clk_en));
			chk("three_ph", 32'(!v[5]), 32'(three_phase_pwm));
			chk("cur_mode", 32'(v[3]), 32'(current_mode));
			chk("auto", 32'(v[2]), 32'(auto_mode));
			chk("zc_byp", 32'(v[1]), 32'(zc_filter_bypass));
			chk("gate", 32'h3f, 32'(gate_level));
		end
		$display("test mode bits done");
		apb(1'b1, 8'h1c, 32'h1);
		apb(1'b1, 8'h00, 32'h40);
		settle(2);
		chk("zc_run", 32'h0, 32'(zc_sampling_run));
		chk("demag", 32'h1, 32'(demag_sampling));
		apb(1'b1, 8'h1c, 32'h0);
		settle(2);
		chk("zc_run", 32'h1, 32'(zc_sampling_run));
		$display("test sampling done");
		apb(1'b1, 8'h00, 32'h0);
		settle(3);
		apb(1'b0, 8'h24, 32'h0);
		chk("pwm_cnt", 32'h0, rd & 32'hfff);
		n = n_upd;
		apb(1'b1, 8'h00, 32'h40);
		settle(12);
		chk("update", 32'h1, 32'(n_upd - n));
		apb(1'b0, 8'h24, 32'h0);
		chk("pwm_run", 32'h1, 32'(rd[11:0] != 12'h0));
		$display("test clock enable done");
		apb(1'b1, 8'h00, 32'h0);
		w = 8'(next_rnd());
		apb(1'b1, 8'h0c, 32'(w));
		rdchk("weight", 8'h0c, 32'(w));
		zc(8'h55);
		rdchk("cur_zc", 8'h14, 32'h0);
		apb(1'b1, 8'h00, 32'h45);
		v1 = 8'(next_rnd());
		v2 = 8'(next_rnd()) | 8'h80;
		v3 = 8'(next_rnd());
		zc(v1);
		zc(v2);
		rdchk("next_cmp", 8'h18, exp_cmp(w, v2));
		rdchk("prev_zc", 8'h10, 32'(v1));
		rdchk("cur_zc", 8'h14, 32'(v2));
		apb(1'b1, 8'h00, 32'h44);
		zc(v3);
		rdchk("next_cmp", 8'h18, exp_cmp(w, v2));
		apb(1'b1, 8'h00, 32'h40);
		apb(1'b1, 8'h18, 32'ha5);
		zc(v1);
		rdchk("next_cmp", 8'h18, 32'ha5);
		$display("test multiplier done");
		apb(1'b1, 8'h08, 32'h0);
		apb(1'b1, 8'h04, 32'h3f);
		n = n_comm;
		@(posedge pclk);
		commutation_event <= 1'b1;
		@(posedge pclk);
		commutation_event <= 1'b0;
		settle(3);
		chk("comm", 32'h1, 32'(n_comm - n));
		apb(1'b1, 8'h00, 32'h88);
		settle(3);
		chk("phase", 32'h15, 32'(phase_outputs));
		apb(1'b1, 8'h00, 32'h80);
		settle(3);
		chk("gate", 32'h3f, 32'(gate_level));
		$display("test clock stop done");
		apb(1'b1, 8'h00, 32'h90);
		repeat (4) begin
			v = next_rnd() & 32'h3f;
			n = n_comm;
			apb(1'b1, 8'h04, v);
			settle(3);
			chk("comm", 32'h1, 32'(n_comm - n));
			chk("phase", v, 32'(phase_outputs));
			chk("oe_n", 32'h0, 32'(phase_outputs_oe_n));
			chk("gate", v, 32'(gate_level));
		end
		apb(1'b1, 8'h00, 32'h10);
		settle(3);
		chk("gate", 32'h3f, 32'(gate_level));
		$display("test direct access done");
		apb(1'b1, 8'h08, 32'h7);
		apb(1'b1, 8'h00, 32'h30);
		apb(1'b1, 8'h04, 32'h0);
		settle(2);
		chk("mode_bits", 32'h5, 32'(output_mode_bits));
		apb(1'b1, 8'h00, 32'h10);
		settle(2);
		chk("mode_bits", 32'h7, 32'(output_mode_bits));
		$display("test output mode done");
		wrap_up();
	end
endmodule // tb_top
